// ===== dv/ssah_card_model.sv
// Card and relay chain as seen at the drive pins
`timescale 1ns/100ps
module ssah_card_model
(
	// Motor and stop button
	input wire over_temp_i,
	input wire relay_open_i,
	input wire fault_i,
	// Drive pins
	output wire safe_stop_n_o,
	output wire card_trip_indicator_o
);
	// High in normal running, low on overtemperature or open relay
	assign safe_stop_n_o = ~over_temp_i & ~relay_open_i;
	// Wired to one input only; fault_i raises it without a stop
	assign card_trip_indicator_o = over_temp_i | fault_i;
endmodule

// ===== dv/ssah_top_sva.sv
// Checker of the safe-stop alarm handler outputs
`timescale 1ns/100ps
module ssah_chk
(
	// Inputs
	input wire ref_clk_i,
	input wire arst_n_i,
	input wire safe_stop_n_i,
	input wire [3:0] digital_input_i,
	input wire card_present_i,
	input wire bus_reset_i,
	input wire local_keypad_reset_i,
	// Outputs
	input wire [3:0] reaction_code_o,
	input wire coast_o,
	input wire relay_stop_alarm_o,
	input wire card_stop_alarm_o,
	input wire card_stop_warning_o,
	input wire dangerous_failure_alarm_o,
	input wire [7:0] alarm_code_o,
	input wire [7:0] warning_code_o
);
	// Loose on purpose: any input pin may carry the reset function
	wire man_rst = bus_reset_i | local_keypad_reset_i | (|digital_input_i);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	chk_code_gate: assert property ($changed(reaction_code_o) && reaction_code_o > 4'h3
		|-> $past(card_present_i)) else $error("code without card");
	chk_alarm_coast: assert property (relay_stop_alarm_o | card_stop_alarm_o
		| dangerous_failure_alarm_o |-> coast_o) else $error("alarm without coast");
	chk_stop_coast: assert property (!safe_stop_n_i [*3] |=> coast_o)
		else $error("stop without coast");
	chk_alarm_hold: assert property ($fell(relay_stop_alarm_o) || $fell(card_stop_alarm_o)
		|-> $past(man_rst) || $past(man_rst, 2) || $past(man_rst, 3))
		else $error("alarm cleared alone");
	chk_danger_lock: assert property ($fell(dangerous_failure_alarm_o)
		|-> $past(man_rst) || $past(man_rst, 2) || $past(man_rst, 3))
		else $error("trip lock cleared alone");
	chk_danger_code: assert property (dangerous_failure_alarm_o |-> alarm_code_o == 8'h48)
		else $error("trip lock code");
	chk_card_code: assert property (card_stop_alarm_o && !dangerous_failure_alarm_o
		|-> alarm_code_o == 8'h47) else $error("card alarm code");
	chk_warn_code: assert property (card_stop_warning_o |-> warning_code_o == 8'h47)
		else $error("card warning code");
endmodule
bind ssah_top ssah_chk ssah_chk_i (.ref_clk_i, .arst_n_i, .safe_stop_n_i, .digital_input_i,
	.card_present_i, .bus_reset_i, .local_keypad_reset_i, .reaction_code_o, .coast_o,
	.relay_stop_alarm_o, .card_stop_alarm_o, .card_stop_warning_o, .dangerous_failure_alarm_o,
	.alarm_code_o, .warning_code_o);

// ===== dv/ssah_top_tb.sv
// Self-checking bench of the safe-stop alarm handler
`timescale 1ns/100ps
`include "ssah_map.vh"
module ssah_top_tb;
	// Rows: code, indicator, alarm code, warning code
	localparam [407:0] ROWS = {24'h104400, 24'h114400, 24'h300044, 24'h310044,
		24'h404800, 24'h414700, 24'h504800, 24'h510047, 24'h604400, 24'h614700,
		24'h700044, 24'h710047, 24'h800044, 24'h814700, 24'h904400, 24'h910047,
		24'h000000};
	reg ref_clk_i = 1'b0;
	reg arst_n_i = 1'b0;
	reg over_temp = 1'b0, relay_open = 1'b0, fault = 1'b0, di1 = 1'b0;
	reg load = 1'b0, present = 1'b1, bus_rst = 1'b0, key_rst = 1'b0;
	reg [7:0] fn1 = `SSAH_FN_NONE;
	reg [3:0] code = 4'h0;
	reg [23:0] row;
	wire safe_n, ind, coast, rsa, rsw, csa, csw, dfa, cfg_err;
	wire [3:0] code_o;
	wire [7:0] acode, wcode;
	integer failures = 0, num_checks = 0, i;
	always #2 ref_clk_i = ~ref_clk_i;
	ssah_card_model ssah_card_model_i (.over_temp_i(over_temp), .relay_open_i(relay_open),
		.fault_i(fault), .safe_stop_n_o(safe_n), .card_trip_indicator_o(ind));
	ssah_top ssah_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .safe_stop_n_i(safe_n),
		.digital_input_i({2'b00, di1, ind}), .di_function_i({16'h0000, fn1, `SSAH_FN_CARD}),
		.reaction_code_i(code), .reaction_load_i(load), .card_present_i(present),
		.bus_reset_i(bus_rst), .local_keypad_reset_i(key_rst), .reaction_code_o(code_o),
		.coast_o(coast), .relay_stop_alarm_o(rsa), .relay_stop_warning_o(rsw),
		.card_stop_alarm_o(csa), .card_stop_warning_o(csw), .dangerous_failure_alarm_o(dfa),
		.alarm_code_o(acode), .warning_code_o(wcode), .config_error_o(cfg_err));
	task chk(input [7:0] got, input [7:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task cyc(input integer n);
	begin
		repeat (n) @(negedge ref_clk_i);
	end
	endtask
	task complete_run;
	begin
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task set_code(input [3:0] c);
	begin
		code = c;
		load = 1'b1;
		cyc(1);
		load = 1'b0;
		cyc(3);
	end
	endtask
	// Causes go away first, so the manual reset is not refused
	task clear;
	begin
		over_temp = 1'b0;
		relay_open = 1'b0;
		fault = 1'b0;
		cyc(5);
		bus_rst = 1'b1;
		cyc(1);
		bus_rst = 1'b0;
		cyc(4);
	end
	endtask
	initial
	begin
		#20000;
		failures = failures + 1;
		complete_run;
	end
	initial
	begin
		cyc(16);
		chk(code_o, 4'h1);
		chk({coast, rsa, rsw, csa, csw, dfa, cfg_err} | acode | wcode, 8'h00);
		arst_n_i = 1'b1;
		cyc(4);
		for (i = 0; i < 17; i = i + 1)
		begin
			row = ROWS[i*24 +: 24];
			set_code(row[23:20]);
			chk(code_o, row[23:20]);
			over_temp = row[16];
			relay_open = ~row[16];
			cyc(5);
			chk(acode, row[15:8]);
			chk(wcode, row[7:0]);
			chk(coast, 1'b1);
			chk({rsa, rsw, csa, csw}, {row[15:8] == `SSAH_CODE_RELAY,
				row[7:0] == `SSAH_CODE_RELAY, row[15:8] == `SSAH_CODE_CARD,
				row[7:0] == `SSAH_CODE_CARD});
			clear;
			chk(acode | wcode, 8'h00);
			chk(coast, 1'b0);
		end
		present = 1'b0;
		set_code(4'h4);
		chk(code_o, 4'h1);
		present = 1'b1;
		set_code(4'h1);
		relay_open = 1'b1;
		cyc(5);
		key_rst = 1'b1;
		cyc(1);
		key_rst = 1'b0;
		cyc(4);
		chk(acode, 8'h44);
		relay_open = 1'b0;
		fn1 = `SSAH_FN_RESET;
		cyc(5);
		di1 = 1'b1;
		cyc(2);
		di1 = 1'b0;
		cyc(5);
		chk(acode, 8'h00);
		set_code(4'h6);
		fault = 1'b1;
		cyc(5);
		chk(dfa, 1'b1);
		fault = 1'b0;
		cyc(8);
		chk(acode, 8'h48);
		clear;
		chk(dfa, 1'b0);
		chk(cfg_err, 1'b0);
		// Mid-run reset drops a latched alarm and restores the default code
		relay_open = 1'b1;
		cyc(5);
		chk(rsa, 1'b1);
		arst_n_i = 1'b0;
		relay_open = 1'b0;
		cyc(2);
		chk(code_o, 4'h1);
		chk(acode, 8'h00);
		arst_n_i = 1'b1;
		cyc(4);
		chk(acode | wcode, 8'h00);
		chk(coast, 1'b0);
		fn1 = `SSAH_FN_CARD;
		cyc(4);
		chk(cfg_err, 1'b1);
		complete_run;
	end
endmodule

// ===== logic/ssah_map.vh
// Constants of the safe-stop alarm handler
// Operation
// (RQ1) Input function codes: none, reset, card-trip
// (RQ2) Card-trip function on one input only
// (RQ3) Card-trip input not motor thermistor source
// (RQ4) Reaction code register, alarm default after reset
// (RQ5) Codes four to nine need card present
// (RQ6) Alarm reactions coast, latch until manual reset
// (RQ7) Card warnings restart when both inputs clear
// (RQ8) Code three restarts when terminal restored
// (RQ9) Codes five, seven hold while indicator asserted
// (RQ10) Four, five card only; six-nine combined
// (RQ11) Report relay and card codes per reaction
// (RQ12) Eight, nine mix alarm and warning
// (RQ13) Indicator input selects reported source
// (RQ14) Safe-stop failure raises dangerous-failure alarm
// (RQ15) Detect unexpected indicator and terminal combinations
// (RQ16) Card output high normal, low on trip
// (RQ17) Dangerous failure latched, no auto clear
`ifndef SSAH_MAP_VH
`define SSAH_MAP_VH

// ----------------------------------------
// Digital input function codes
// ----------------------------------------
`define SSAH_FN_NONE 8'h00
`define SSAH_FN_RESET 8'h01
`define SSAH_FN_CARD 8'h50

// ----------------------------------------
// Reaction codes
// ----------------------------------------
`define SSAH_RC_OFF 4'h0
`define SSAH_RC_ALARM 4'h1
`define SSAH_RC_WARN 4'h3
`define SSAH_RC_CARD_A 4'h4
`define SSAH_RC_CARD_W 4'h5
`define SSAH_RC_BOTH_A 4'h6
`define SSAH_RC_BOTH_W 4'h7
`define SSAH_RC_BOTH_AW 4'h8
`define SSAH_RC_BOTH_WA 4'h9
`define SSAH_RC_RESET 4'h1

// ----------------------------------------
// Reported codes
// ----------------------------------------
`define SSAH_CODE_RELAY 8'h44
`define SSAH_CODE_CARD 8'h47
`define SSAH_CODE_DANGER 8'h48

// ----------------------------------------
// Input count
// ----------------------------------------
`define SSAH_NUM_DI 4
// Synchroniser reset: terminal bit idles high, digital inputs low
`define SSAH_SYNC_RST {1'b1, {`SSAH_NUM_DI{1'b0}}}

`endif

// ===== logic/ssah_sync.v
// Two-stage synchroniser for a bank of pin inputs
`timescale 1ns/100ps
module ssah_sync
#(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}}
)
(
	// Clock and reset
	input wire ref_clk_i,
	input wire arst_n_i,
	// Data
	input wire [W-1:0] async_i,
	output reg [W-1:0] sync_o
);
	reg [W-1:0] meta_q;

	// Each bit resets to its pin's idle level, so no false event follows reset
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_q <= RST;
			sync_o <= RST;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ===== logic/ssah_top.v
// Safe-stop alarm handler with thermistor card support
`timescale 1ns/100ps
`include "ssah_map.vh"
module ssah_top
(
	// Clock and reset
	input wire ref_clk_i,
	input wire arst_n_i,
	// Pins: safe-stop terminal (low = stop) and digital inputs
	input wire safe_stop_n_i,
	input wire [`SSAH_NUM_DI-1:0] digital_input_i,
	// Configuration
	input wire [4*8-1:0] di_function_i,
	input wire [3:0] reaction_code_i,
	input wire reaction_load_i,
	input wire card_present_i,
	// Reset commands from bus and keypad
	input wire bus_reset_i,
	input wire local_keypad_reset_i,
	// Status
	output reg [3:0] reaction_code_o,
	output reg coast_o,
	output reg relay_stop_alarm_o,
	output reg relay_stop_warning_o,
	output reg card_stop_alarm_o,
	output reg card_stop_warning_o,
	output reg dangerous_failure_alarm_o,
	output reg [7:0] alarm_code_o,
	output reg [7:0] warning_code_o,
	output reg config_error_o
);
	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	wire [`SSAH_NUM_DI:0] pins_s;
	ssah_sync #(.W(`SSAH_NUM_DI+1), .RST(`SSAH_SYNC_RST)) u_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.async_i({safe_stop_n_i, digital_input_i}),
		.sync_o(pins_s)
	);
	wire ss_active = ~pins_s[`SSAH_NUM_DI];
	wire [`SSAH_NUM_DI-1:0] di_s = pins_s[`SSAH_NUM_DI-1:0];

	// ----------------------------------------
	// Input function decode
	// ----------------------------------------
	wire [`SSAH_NUM_DI-1:0] is_reset;
	wire [`SSAH_NUM_DI-1:0] is_card;
	genvar g;
	generate
		for (g = 0; g < `SSAH_NUM_DI; g = g + 1)
		begin : g_di
			// Unknown codes behave as no operation
			assign is_reset[g] = (di_function_i[g*8 +: 8] == `SSAH_FN_RESET); // [RQ1]
			assign is_card[g] = (di_function_i[g*8 +: 8] == `SSAH_FN_CARD); // [RQ1]
		end
	endgenerate
	wire di_reset = |(is_reset & di_s);
	wire card_trip = |(is_card & di_s); // [RQ13]
	wire card_fn_any = |is_card;
	// Several card-trip inputs is a configuration fault of the far side
	wire card_fn_multi = (is_card & (is_card - 1'b1)) != {`SSAH_NUM_DI{1'b0}}; // [RQ2]

	// ----------------------------------------
	// Reaction code register
	// ----------------------------------------
	reg [3:0] rc_q;
	wire rc_card_code = (reaction_code_i >= `SSAH_RC_CARD_A) &&
		(reaction_code_i <= `SSAH_RC_BOTH_WA);
	wire rc_legal = (reaction_code_i == `SSAH_RC_OFF) || (reaction_code_i == `SSAH_RC_ALARM) ||
		(reaction_code_i == `SSAH_RC_WARN) || (rc_card_code && card_present_i); // [RQ5]
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rc_q <= `SSAH_RC_RESET; // [RQ4]
		else if (reaction_load_i && rc_legal)
			rc_q <= reaction_code_i; // [RQ4]
	end

	// ----------------------------------------
	// Per-code behaviour
	// ----------------------------------------
	reg relay_alarm;
	reg relay_warn;
	reg card_alarm;
	reg card_warn;
	reg card_only;
	always @*
	begin
		relay_alarm = 1'b0;
		relay_warn = 1'b0;
		card_alarm = 1'b0;
		card_warn = 1'b0;
		card_only = 1'b0;
		case (rc_q)
			`SSAH_RC_ALARM: relay_alarm = 1'b1; // [RQ11]
			`SSAH_RC_WARN: relay_warn = 1'b1; // [RQ11]
			`SSAH_RC_CARD_A:
			begin
				card_alarm = 1'b1;
				card_only = 1'b1; // [RQ10]
			end
			`SSAH_RC_CARD_W:
			begin
				card_warn = 1'b1;
				card_only = 1'b1; // [RQ10]
			end
			`SSAH_RC_BOTH_A:
			begin
				card_alarm = 1'b1;
				relay_alarm = 1'b1; // [RQ11]
			end
			`SSAH_RC_BOTH_W:
			begin
				card_warn = 1'b1;
				relay_warn = 1'b1; // [RQ11]
			end
			`SSAH_RC_BOTH_AW:
			begin
				card_alarm = 1'b1;
				relay_warn = 1'b1; // [RQ12]
			end
			`SSAH_RC_BOTH_WA:
			begin
				card_warn = 1'b1;
				relay_alarm = 1'b1; // [RQ12]
			end
			default:
			begin
				relay_alarm = 1'b0;
			end
		endcase
	end
	wire card_mode = card_alarm | card_warn;
	// Indicator is ignored where no card code is chosen
	wire trip_seen = card_mode & card_trip;

	// ----------------------------------------
	// Source classification and fault detect
	// ----------------------------------------
	wire from_card = ss_active & trip_seen; // [RQ13]
	wire from_relay = ss_active & ~trip_seen & ~card_only; // [RQ10]
	wire danger_now = card_mode & ((trip_seen & ~ss_active) |
		(card_only & ss_active & ~card_trip)); // [RQ15]
	wire manual_reset = bus_reset_i | local_keypad_reset_i | di_reset;

	// ----------------------------------------
	// Latches
	// ----------------------------------------
	reg ra_q;
	reg ca_q;
	reg df_q;
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ra_q <= 1'b0;
			ca_q <= 1'b0;
			df_q <= 1'b0;
		end
		else
		begin
			// Set wins over reset while the cause stands
			if (from_relay && relay_alarm)
				ra_q <= 1'b1; // [RQ6]
			else if (manual_reset && !ss_active)
				ra_q <= 1'b0; // [RQ6]
			if (from_card && card_alarm)
				ca_q <= 1'b1; // [RQ6]
			else if (manual_reset && !ss_active && !card_trip)
				ca_q <= 1'b0; // [RQ6]
			// Trip lock: only a manual reset with the cause gone clears it
			if (danger_now)
				df_q <= 1'b1; // [RQ14]
			else if (manual_reset)
				df_q <= 1'b0; // [RQ17]
		end
	end

	// Warnings follow live conditions; restart is automatic
	wire rw_now = from_relay & relay_warn; // [RQ8]
	// Only the indicator names the card as source; a bare stop is no card warning
	wire cw_now = card_warn & trip_seen; // [RQ9]
	// Coasting stays while safe stop or a card warning hold, or any latch
	wire coast_now = ss_active | ra_q | ca_q | df_q | cw_now |
		(from_relay & relay_alarm) | (from_card & card_alarm); // [RQ7]

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			reaction_code_o <= `SSAH_RC_RESET;
			coast_o <= 1'b0;
			relay_stop_alarm_o <= 1'b0;
			relay_stop_warning_o <= 1'b0;
			card_stop_alarm_o <= 1'b0;
			card_stop_warning_o <= 1'b0;
			dangerous_failure_alarm_o <= 1'b0;
			alarm_code_o <= 8'h00;
			warning_code_o <= 8'h00;
			config_error_o <= 1'b0;
		end
		else
		begin
			reaction_code_o <= rc_q;
			coast_o <= coast_now; // [RQ7]
			relay_stop_alarm_o <= ra_q;
			relay_stop_warning_o <= rw_now; // [RQ8]
			card_stop_alarm_o <= ca_q;
			card_stop_warning_o <= cw_now; // [RQ9]
			dangerous_failure_alarm_o <= df_q; // [RQ14]
			// Highest-priority alarm is shown when several are latched
			if (df_q)
				alarm_code_o <= `SSAH_CODE_DANGER; // [RQ14]
			else if (ca_q)
				alarm_code_o <= `SSAH_CODE_CARD; // [RQ11]
			else if (ra_q)
				alarm_code_o <= `SSAH_CODE_RELAY; // [RQ11]
			else
				alarm_code_o <= 8'h00;
			if (cw_now)
				warning_code_o <= `SSAH_CODE_CARD; // [RQ11]
			else if (rw_now)
				warning_code_o <= `SSAH_CODE_RELAY; // [RQ11]
			else
				warning_code_o <= 8'h00;
			config_error_o <= card_fn_multi | (card_mode & ~card_fn_any); // [RQ2]
		end
	end
endmodule
